//--- design/dtc_timer.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// R01 - counter 0 uses low mode nibble and control bits 5, 4, 1, 0
// R02 - counter 1 uses high mode nibble and control bits 7, 6, 3, 2
// R03 - gate select 0: run bit alone enables counting of the low byte
// R04 - gate select and run set: count only while gate pin is high
// R05 - rollover from all ones to zero sets the overflow flag
// R06 - mode 0: five-bit prescaler in low byte carries into high byte
// R07 - software ignores upper three low-byte bits in mode 0
// R08 - mode 1: low and high bytes cascade as one 16-bit counter
// R09 - mode 2: low byte overflows, reloads from high byte, high unchanged
// R10 - servicing the request clears the overflow flag in hardware
// R11 - counter 0 mode 3: low byte is a normal 8-bit counter
// R12 - counter 0 mode 3: high byte times, runs on run bit one, sets flag one
// R13 - counter 0 mode 3: counter 1 loses its run bit and flag
// R14 - counter 1 mode 3 halts and holds its count
// R15 - counter 1 modes 0-2 match counter 0; overflow feeds baud tick
// R16 - mode bits 00, 01, 10, 11 select modes 0, 1, 2, 3
// R17 - source select 0 counts divided clock, 1 counts pin falls
// R18 - timer counts once per peripheral cycle of twelve clocks
// R19 - pin sampled once per peripheral cycle; high then low counts
// R20 - software writes to count bytes win over a same-cycle increment
module dtc_timer
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic countPinZero,
  input wire logic countPinOne,
  input wire logic extGatePinZero,
  input wire logic extGatePinOne,
  // interrupt service acknowledge
  input wire logic ackZero,
  input wire logic ackOne,
  // requests and baud source
  output logic overflowReqZero,
  output logic overflowReqOne,
  output logic extIrqReqZero,
  output logic extIrqReqOne,
  output logic baudTick
);

  function automatic logic [16:0] dtc_step(input dtc_mode_type m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [8:0] s;
    logic [5:0] p;
    logic [8:0] h;
    s = {1'b0, lo} + 9'h001;
    p = {1'b0, lo[4:0]} + 6'h01;
    h = {1'b0, hi} + 9'h001;
    case (m)
      MODE_PRESC13: begin // see R06
        if (p[5]) begin
          dtc_step = {h[8], h[7:0], lo[7:5], p[4:0]};
        end else begin
          dtc_step = {1'b0, hi, lo[7:5], p[4:0]};
        end
      end
      MODE_CASCADE16: begin // see R08
        if (s[8]) begin
          dtc_step = {h[8], h[7:0], s[7:0]};
        end else begin
          dtc_step = {1'b0, hi, s[7:0]};
        end
      end
      MODE_RELOAD8: begin // see R09
        dtc_step = {s[8], hi, s[8] ? hi : s[7:0]};
      end
      default: begin
        dtc_step = {1'b0, hi, lo}; // see R14
      end
    endcase
  endfunction

  function automatic logic [7:0] dtc_idx(input logic [31:0] a);
    dtc_idx = a[9:2];
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic wrPend, next_wrPend;
  logic [7:0] wrIdx, next_wrIdx;
  logic [31:0] next_hrdata;
  logic addrOk;
  logic [7:0] ctrl, mode, lo0, hi0, lo1, hi1;

  always_comb begin
    addrOk = hsel && htrans[1] && hready && (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    next_wrPend = addrOk && hwrite;
    next_wrIdx = dtc_idx(haddr);
    next_hrdata = hrdata;
    if (addrOk && !hwrite) begin
      case (dtc_idx(haddr))
        CTRL_IDX: next_hrdata = {24'h0, ctrl};
        MODE_IDX: next_hrdata = {24'h0, mode};
        LOW0_IDX: next_hrdata = {24'h0, lo0};
        HIGH0_IDX: next_hrdata = {24'h0, hi0};
        LOW1_IDX: next_hrdata = {24'h0, lo1};
        HIGH1_IDX: next_hrdata = {24'h0, hi1};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrIdx <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wrPend <= next_wrPend;
      wrIdx <= next_wrIdx;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinMeta, pinSync, next_pinMeta, next_pinSync;

  always_comb begin
    next_pinMeta = {extGatePinOne, extGatePinZero, countPinOne, countPinZero};
    next_pinSync = pinMeta;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= 4'hf;
      pinSync <= 4'hf;
    end else begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  logic [3:0] presc, next_presc;
  logic [1:0] lastCnt, next_lastCnt, lastGate, next_lastGate;
  logic [7:0] next_ctrl, next_mode, next_lo0, next_hi0, next_lo1, next_hi1;
  logic next_baud;
  logic tick, split, en0, en1, inc0, inc1, set0, set1, ovf1, fall0, fall1;
  logic wrLo0, wrHi0, wrLo1, wrHi1, wrCtrl;
  dtc_mode_type m0, m1;
  logic [16:0] r0, r1;
  logic [8:0] sum0, sumH;

  always_comb begin
    tick = (presc == PERIPH_LAST); // see R18
    next_presc = tick ? 4'h0 : 4'(presc + 4'h1);
    next_lastCnt = tick ? pinSync[1:0] : lastCnt;
    next_lastGate = pinSync[3:2];
    fall0 = tick && lastCnt[0] && !pinSync[0]; // see R19
    fall1 = tick && lastCnt[1] && !pinSync[1]; // see R19
    m0 = dtc_mode_type'(mode[NIB0_LSB +: 2]); // see R01, R16
    m1 = dtc_mode_type'(mode[NIB1_LSB +: 2]); // see R02, R16
    split = (m0 == MODE_SPLIT_HOLD);
    // see R03, R04
    en0 = ctrl[TR0_BIT] && (!mode[NIB0_LSB + GATE_OFS] || pinSync[2]);
    // see R13
    en1 = (split || ctrl[TR1_BIT]) && (!mode[NIB1_LSB + GATE_OFS] || pinSync[3]);
    // see R17
    inc0 = en0 && (mode[NIB0_LSB + SRC_OFS] ? fall0 : tick);
    inc1 = en1 && (mode[NIB1_LSB + SRC_OFS] ? fall1 : tick);
    wrCtrl = wrPend && (wrIdx == CTRL_IDX);
    wrLo0 = wrPend && (wrIdx == LOW0_IDX);
    wrHi0 = wrPend && (wrIdx == HIGH0_IDX);
    wrLo1 = wrPend && (wrIdx == LOW1_IDX);
    wrHi1 = wrPend && (wrIdx == HIGH1_IDX);
    next_ctrl = ctrl;
    next_mode = (wrPend && (wrIdx == MODE_IDX)) ? hwdata[7:0] : mode;
    next_lo0 = lo0;
    next_hi0 = hi0;
    next_lo1 = lo1;
    next_hi1 = hi1;
    set0 = 1'b0;
    set1 = 1'b0;
    sum0 = {1'b0, lo0} + 9'h001;
    sumH = {1'b0, hi0} + 9'h001;
    r0 = dtc_step(m0, lo0, hi0);
    r1 = dtc_step(m1, lo1, hi1);
    ovf1 = inc1 && r1[16];
    if (inc0) begin
      if (split) begin
        next_lo0 = sum0[7:0]; // see R11
        set0 = sum0[8];
      end else begin
        {set0, next_hi0, next_lo0} = r0; // see R05
      end
    end
    if (split && ctrl[TR1_BIT] && tick) begin
      next_hi0 = sumH[7:0]; // see R12
      set1 = sumH[8];
    end
    if (inc1) begin
      {next_hi1, next_lo1} = r1[15:0]; // see R15
    end
    if (!split) begin
      set1 = ovf1; // see R05, R13
    end
    next_baud = ovf1; // see R15
    // software load beats increment
    if (wrLo0) next_lo0 = hwdata[7:0]; // see R20
    if (wrHi0) next_hi0 = hwdata[7:0]; // see R20
    if (wrLo1) next_lo1 = hwdata[7:0]; // see R20
    if (wrHi1) next_hi1 = hwdata[7:0]; // see R20
    if (ackZero) next_ctrl[TF0_BIT] = 1'b0; // see R10
    if (ackOne) next_ctrl[TF1_BIT] = 1'b0; // see R10
    if (wrCtrl) next_ctrl = hwdata[7:0];
    // hardware sets win over clears
    if (set0) next_ctrl[TF0_BIT] = 1'b1; // see R05
    if (set1) next_ctrl[TF1_BIT] = 1'b1; // see R05, R12
    if (!ctrl[IT0_BIT]) begin
      next_ctrl[IE0_BIT] = !pinSync[2];
    end else if (lastGate[0] && !pinSync[2]) begin
      next_ctrl[IE0_BIT] = 1'b1;
    end
    if (!ctrl[IT1_BIT]) begin
      next_ctrl[IE1_BIT] = !pinSync[3];
    end else if (lastGate[1] && !pinSync[3]) begin
      next_ctrl[IE1_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      presc <= 4'h0;
      lastCnt <= 2'h3;
      lastGate <= 2'h3;
      ctrl <= REG_RESET;
      mode <= REG_RESET;
      lo0 <= REG_RESET;
      hi0 <= REG_RESET;
      lo1 <= REG_RESET;
      hi1 <= REG_RESET;
      baudTick <= 1'b0;
      overflowReqZero <= 1'b0;
      overflowReqOne <= 1'b0;
      extIrqReqZero <= 1'b0;
      extIrqReqOne <= 1'b0;
    end else begin
      presc <= next_presc;
      lastCnt <= next_lastCnt;
      lastGate <= next_lastGate;
      ctrl <= next_ctrl;
      mode <= next_mode;
      lo0 <= next_lo0;
      hi0 <= next_hi0;
      lo1 <= next_lo1;
      hi1 <= next_hi1;
      baudTick <= next_baud;
      overflowReqZero <= next_ctrl[TF0_BIT];
      overflowReqOne <= next_ctrl[TF1_BIT];
      extIrqReqZero <= next_ctrl[IE0_BIT];
      extIrqReqOne <= next_ctrl[IE1_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_tick_period: assert property (tick |-> ##12 tick) // see R18
    else $error("peripheral tick not every twelve clocks");
  a_run_stop: assert property ((!ctrl[TR0_BIT] && !wrLo0 && !wrHi0 && !split)
    |=> $stable({hi0, lo0})) // see R03
    else $error("counter zero moved while stopped");
  a_gate_hold: assert property ((mode[NIB0_LSB + GATE_OFS] && !pinSync[2] && !wrLo0 && !wrHi0
    && !split) |=> $stable({hi0, lo0})) // see R04
    else $error("counter zero moved with gate pin low");
  a_overflow_set: assert property (set0 |=> ctrl[TF0_BIT] ##0 overflowReqZero) // see R05
    else $error("overflow did not raise flag zero");
  a_reload_high: assert property ((m0 == MODE_RELOAD8 && inc0 && lo0 == BYTE_FULL && !wrLo0
    && !wrHi0) |=> (lo0 == $past(hi0)) && $stable(hi0)) // see R09
    else $error("mode 2 reload wrong");
  a_ack_clear: assert property ((ackZero && !set0 && !wrCtrl) |=> !ctrl[TF0_BIT]) // see R10
    else $error("ack did not clear flag zero");
  a_hold_count: assert property ((m1 == MODE_SPLIT_HOLD && !wrLo1 && !wrHi1)
    |=> $stable({hi1, lo1})) // see R14
    else $error("counter one moved in hold mode");
  a_write_wins: assert property (wrLo0 |=> lo0 == $past(hwdata[7:0])) // see R20
    else $error("low byte write lost");
  a_presc_carry: assert property ((m0 == MODE_PRESC13 && inc0 && lo0[4:0] == PRESC_FULL
    && !wrHi0 && !wrLo0) |=> hi0 == 8'($past(hi0) + 8'h01)) // see R06
    else $error("prescaler carry missing");
  a_split_high: assert property ((split && ctrl[TR1_BIT] && tick && hi0 == BYTE_FULL)
    |=> ctrl[TF1_BIT]) // see R12
    else $error("split high byte overflow missed");

endmodule // dtc_timer

//--- dv/dtc_timer_test.sv
`timescale 1ns/1ps
module dtc_timer_test
  import dtc_pkg::*;
;
  // ------------------------------
  // signals, monitors, bus tasks
  // ------------------------------
  logic mclk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic cntZ = 1'h1, cntO = 1'h1, gateZ = 1'h1, gateO = 1'h1, ackZ = 1'h0, ackO = 1'h0;
  logic hreadyout, hresp, ovfZ, ovfO, baudTick, irqZ, irqO;
  logic sawZ = 1'h0, sawO = 1'h0, sawB = 1'h0;
  int badCount = 0, samplesChecked = 0, cycles = 0;

  dtc_timer DUT (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .countPinZero(cntZ), .countPinOne(cntO), .extGatePinZero(gateZ),
    .extGatePinOne(gateO), .ackZero(ackZ), .ackOne(ackO),
    .overflowReqZero(ovfZ), .overflowReqOne(ovfO), .extIrqReqZero(irqZ),
    .extIrqReqOne(irqO), .baudTick(baudTick));

  always #25 mclk = ~mclk;

  // latch short pulses and cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (ovfZ === 1'h1) sawZ <= 1'h1;
    if (ovfO === 1'h1) sawO <= 1'h1;
    if (baudTick === 1'h1) sawB <= 1'h1;
    if (cycles == 6000) begin
      badCount++;
      $display("CHECK FAILED at %0t: timeout", $time);
      giveVerdict();
    end
  end

  task automatic check(input logic [31:0] got, exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic busXfer(input logic wr, input logic [7:0] i, d);
    hsel <= 1'h1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, d);
    busXfer(1'h1, i, d);
  endtask

  task automatic rdc(input logic [7:0] i, exp, input string msg);
    busXfer(1'h0, i, 8'h0);
    check(rd, {24'h0, exp}, msg);
  endtask

  // run bits held for exactly twelve clocks: one peripheral tick
  // stale flags are cleared first so the latches only see this run
  task automatic runOne(input logic [7:0] v);
    wr(CTRL_IDX, 8'h0);
    @(posedge mclk);
    sawZ = 1'h0;
    sawO = 1'h0;
    sawB = 1'h0;
    wr(CTRL_IDX, v);
    repeat (10) @(posedge mclk);
    wr(CTRL_IDX, 8'h0);
  endtask

  task automatic flags(input logic z, o);
    check({31'h0, sawZ}, {31'h0, z}, "flag zero");
    check({31'h0, sawO}, {31'h0, o}, "flag one");
  endtask

  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic testRegs();
    for (int k = 0; k < 6; k++) rdc(CTRL_IDX + 8'(k), REG_RESET, "reset");
    wr(MODE_IDX, 8'ha5);
    rdc(MODE_IDX, 8'ha5, "mode rw");
    wr(8'h80, 8'h55);
    rdc(8'h80, 8'h00, "unmapped");
    check({31'h0, hresp}, 32'h0, "okay response");
    $display("regs done");
  endtask

  task automatic testModes();
    wr(MODE_IDX, 8'h01);
    wr(LOW0_IDX, 8'hff);
    wr(HIGH0_IDX, 8'hff);
    runOne(8'h10);
    rdc(LOW0_IDX, 8'h00, "cascade low");
    rdc(HIGH0_IDX, 8'h00, "cascade high");
    flags(1'h1, 1'h0);
    wr(MODE_IDX, 8'h00);
    wr(LOW0_IDX, 8'h1f);
    wr(HIGH0_IDX, 8'hff);
    runOne(8'h10);
    busXfer(1'h0, LOW0_IDX, 8'h0);
    check(rd & 32'h1f, 32'h0, "presc low");
    rdc(HIGH0_IDX, 8'h00, "presc high");
    flags(1'h1, 1'h0);
    wr(MODE_IDX, 8'h22);
    wr(HIGH0_IDX, 8'h80);
    wr(LOW0_IDX, 8'hff);
    wr(HIGH1_IDX, 8'hf0);
    wr(LOW1_IDX, 8'hff);
    runOne(8'h50);
    rdc(LOW0_IDX, 8'h80, "reload low zero");
    rdc(HIGH0_IDX, 8'h80, "reload high zero");
    rdc(LOW1_IDX, 8'hf0, "reload low");
    rdc(HIGH1_IDX, 8'hf0, "reload high");
    flags(1'h1, 1'h1);
    check({31'h0, sawB}, 32'h1, "baud");
    $display("modes done");
  endtask

  task automatic testGate();
    wr(MODE_IDX, 8'h09);
    wr(LOW0_IDX, 8'h10);
    gateZ <= 1'h0;
    repeat (4) @(posedge mclk);
    check({31'h0, irqZ}, 32'h1, "level irq");
    runOne(8'h10);
    rdc(LOW0_IDX, 8'h10, "gate closed");
    gateZ <= 1'h1;
    repeat (4) @(posedge mclk);
    runOne(8'h10);
    rdc(LOW0_IDX, 8'h11, "gate open");
    wr(MODE_IDX, 8'h05);
    wr(LOW0_IDX, 8'h00);
    wr(CTRL_IDX, 8'h10);
    repeat (30) @(posedge mclk);
    cntZ <= 1'h0;
    repeat (30) @(posedge mclk);
    wr(CTRL_IDX, 8'h00);
    rdc(LOW0_IDX, 8'h01, "one fall");
    cntZ <= 1'h1;
    wr(CTRL_IDX, 8'h04);
    gateO <= 1'h0;
    repeat (4) @(posedge mclk);
    gateO <= 1'h1;
    repeat (4) @(posedge mclk);
    check({31'h0, irqO}, 32'h1, "edge irq held");
    wr(CTRL_IDX, 8'h00);
    @(posedge mclk);
    check({31'h0, irqO}, 32'h0, "irq cleared");
    $display("gate done");
  endtask

  task automatic testSplit();
    wr(MODE_IDX, 8'h03);
    wr(LOW0_IDX, 8'h40);
    wr(HIGH0_IDX, 8'hff);
    runOne(8'h40);
    rdc(HIGH0_IDX, 8'h00, "split high");
    rdc(LOW0_IDX, 8'h40, "split low");
    flags(1'h0, 1'h1);
    wr(MODE_IDX, 8'h30);
    wr(LOW1_IDX, 8'h33);
    runOne(8'h40);
    rdc(LOW1_IDX, 8'h33, "hold");
    flags(1'h0, 1'h0);
    wr(CTRL_IDX, 8'ha0);
    ackZ <= 1'h1;
    @(posedge mclk);
    ackZ <= 1'h0;
    rdc(CTRL_IDX, 8'h80, "ack zero");
    ackO <= 1'h1;
    @(posedge mclk);
    ackO <= 1'h0;
    rdc(CTRL_IDX, 8'h00, "ack one");
    $display("split done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    testRegs();
    testModes();
    testGate();
    testSplit();
    giveVerdict();
  end
endmodule // dtc_timer_test

//--- include/dtc_pkg.sv
package dtc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h88;
  localparam logic [7:0] MODE_IDX = 8'h89;
  localparam logic [7:0] LOW0_IDX = 8'h8a;
  localparam logic [7:0] LOW1_IDX = 8'h8b;
  localparam logic [7:0] HIGH0_IDX = 8'h8c;
  localparam logic [7:0] HIGH1_IDX = 8'h8d;
  localparam logic [7:0] REG_RESET = 8'h00;
  // control register bits
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;
  localparam int IE1_BIT = 3;
  localparam int IT1_BIT = 2;
  localparam int IE0_BIT = 1;
  localparam int IT0_BIT = 0;
  // mode register: nibble base per counter, fields inside a nibble
  localparam int NIB0_LSB = 0;
  localparam int NIB1_LSB = 4;
  localparam int GATE_OFS = 3;
  localparam int SRC_OFS = 2;
  // one peripheral cycle is twelve clocks
  localparam int PERIPH_CLOCKS = 12;
  localparam logic [3:0] PERIPH_LAST = 4'(PERIPH_CLOCKS - 1);
  localparam logic [4:0] PRESC_FULL = 5'h1f;
  localparam logic [7:0] BYTE_FULL = 8'hff;
  typedef enum logic [1:0] {
    MODE_PRESC13,
    MODE_CASCADE16,
    MODE_RELOAD8,
    MODE_SPLIT_HOLD
  } dtc_mode_type;
endpackage
